// ==== motor_prot_pkg.sv ====
package motor_prot_pkg;

    // --------
    // Timing
    // --------
    localparam int CLK_PERIOD_NS = 5;
    localparam int HALF_SEC_NS   = 500_000_000;
    localparam int TICK_CYCLES   = HALF_SEC_NS / CLK_PERIOD_NS;

    // --------
    // Register word indexes (byte address = index * 4)
    // --------
    localparam logic [4:0] IDX_CTRL   = 5'h00;
    localparam logic [4:0] IDX_PWR    = 5'h01;
    localparam logic [4:0] IDX_PDLY   = 5'h02;
    localparam logic [4:0] IDX_ACCEL  = 5'h03;
    localparam logic [4:0] IDX_CURR   = 5'h04;
    localparam logic [4:0] IDX_CDLY   = 5'h05;
    localparam logic [4:0] IDX_VLOW   = 5'h06;
    localparam logic [4:0] IDX_VHIGH  = 5'h07;
    localparam logic [4:0] IDX_VDLY   = 5'h08;
    localparam logic [4:0] IDX_INCFG  = 5'h09;
    localparam logic [4:0] IDX_STATUS = 5'h13;
    localparam logic [4:0] IDX_INSTAT = 5'h14;
    localparam int         NUM_CFG    = 19;
    localparam int         NUM_INPUTS = 10;

    // --------
    // Reset values
    // --------
    localparam logic [31:0] RST_PDLY = 32'h0000_0A0A;
    localparam logic [31:0] RST_CDLY = 32'h0006_0A0A;
    localparam logic [31:0] RST_VDLY = 32'h0A0A_0A0A;

    // --------
    // Field positions
    // --------
    localparam int CTRL_PT_EN    = 0;
    localparam int CTRL_KEY_ALM  = 1;
    localparam int CTRL_ISO_EN   = 2;
    localparam int VLEV_EN_LO    = 15;
    localparam int VLEV_EN_HI    = 31;
    localparam int IN_LATCHED    = 5;
    localparam int IN_INST_ALM   = 6;
    localparam int IN_POL_NC     = 7;
    localparam logic [11:0] OVR_OFF = 12'h_FFF;

    // Input functions
    localparam logic [4:0] FN_NOT_USED = 5'h00;
    localparam logic [4:0] FN_PROC_A   = 5'h01;
    localparam logic [4:0] FN_PROC_J   = 5'h0A;
    localparam logic [4:0] FN_PLANT    = 5'h0B;

    // Stall level unit is 0.05 x full_load_current, i.e. 5 %
    localparam logic [9:0] STALL_STEP_PCT = 10'h005;
    localparam logic [9:0] FULL_LOAD_PCT  = 10'h064;

    // --------
    // Carriers
    // --------
    typedef struct packed {
        logic overVolt;
        logic underVolt;
        logic underCurrent;
        logic loadIncrease;
        logic accel;
        logic lowPower;
    } alarms_t;

    typedef struct packed {
        logic interlock;
        logic plant;
        logic isolator;
        logic overVolt;
        logic underVolt;
        logic stall;
        logic underCurrent;
        logic accel;
        logic lowPower;
    } trips_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RESP = 2'b01
    } rd_state_t;

endpackage

// ==== motor_load_voltage_protection.sv ====
`timescale 1ns/1ps
// Functional notes
// - Key-reset acceleration alarm latches when option enabled
// - Power and voltage elements off without transformer
// - Low-power alarm after level and delay
// - Low-power trip while running, OFF disables
// - Low-power trip delay restarts after each dip
// - Acceleration alarm if current stays high
// - Acceleration trip if current stays high
// - Load-increase alarm above percent of full load
// - Low-current alarm after level and delay
// - Low-current trip while running after delay
// - Stall trip above multiple, not during inrush
// - Stall trip only after stall delay
// - Low-voltage alarm after level and delay
// - Low-voltage trip while running after delay
// - High-voltage alarm after level and delay
// - High-voltage trip while running after delay
// - Ten inputs with individual settings
// - Override delays 0 to 4094 s or OFF
// - Interlock action stop or latched trip
// - Contact polarity selects healthy state
// - Isolator trip held while input open
// - Function asserted when input open without NC polarity, or when closed with NC polarity
// - Interlock trip after startup or running override delay
// - Instantaneous interlock alarm, no delay
// - Duplicate function assignment rejected
module motor_load_voltage_protection
    import motor_prot_pkg::*;
#(
    parameter int TICK_CYC = motor_prot_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst,
    // AXI4-Lite write
    input  wire logic [6:0]                       s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [6:0]                       s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // Measurements
    input  wire logic [13:0]                      powerKw,
    input  wire logic [9:0]                       currentPct,
    input  wire logic [9:0]                       lineVolts,
    input  wire logic                             motorRunning,
    input  wire logic                             startCmd,
    // Field pins
    input  wire logic [motor_prot_pkg::NUM_INPUTS-1:0] switchClosed,
    input  wire logic                             isolatorClosed,
    input  wire logic                             resetKey,
    // Protection outputs
    output motor_prot_pkg::alarms_t               alarms,
    output motor_prot_pkg::trips_t                trips,
    output logic [motor_prot_pkg::NUM_INPUTS-1:0] interlockAlarm,
    output logic                                  interlockStop
);

    localparam int NT = 11 + NUM_INPUTS;
    localparam int NP = NUM_INPUTS + 2;

    // --------
    // Register storage and bus slave
    // --------
    logic [31:0]     cfg_q [NUM_CFG];
    logic [4:0]      awIdx_q;
    logic            awHave_q;
    logic [31:0]     wData_q;
    logic [3:0]      wStrb_q;
    logic            wHave_q;
    logic            bValid_q;
    logic [1:0]      bResp_q;
    rd_state_t       rdState_q;
    logic [31:0]     rData_q;
    logic [1:0]      rResp_q;
    logic [31:0]     statusWord;
    logic [31:0]     inStatWord;
    logic            doWrite;
    logic            wrMapped;
    logic            wrIsIn;
    logic [4:0]      wrIn;
    logic [NUM_INPUTS-1:0] dupHit;
    logic            wrReject;
    logic [4:0]      arIdx;
    logic            rdMapped;
    logic [31:0]     rdMux;
    logic [31:0]     wMerged;
    logic [31:0]     wMask;

    assign s_axi_awready = !awHave_q;
    assign s_axi_wready  = !wHave_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = (rdState_q == RD_IDLE);
    assign s_axi_rvalid  = (rdState_q == RD_RESP);
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;

    // Write decode and duplicate-function check
    assign doWrite  = awHave_q && wHave_q && !bValid_q;
    assign wrMapped = awIdx_q < IDX_STATUS;
    assign wrIsIn   = wrMapped && (awIdx_q >= IDX_INCFG);
    assign wrIn     = awIdx_q - IDX_INCFG;
    assign wMask    = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    assign wMerged  = (wData_q & wMask) | (cfg_q[awIdx_q] & ~wMask);
    assign wrReject = wrIsIn && (|dupHit);

    // Write address and data capture, in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHave_q <= 1'b0;
            awIdx_q  <= 5'h00;
            wHave_q  <= 1'b0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && !awHave_q) begin
                awHave_q <= 1'b1;
                awIdx_q  <= s_axi_awaddr[6:2];
            end else if (doWrite) begin
                awHave_q <= 1'b0;
            end
            if (s_axi_wvalid && !wHave_q) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHave_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bValid_q <= 1'b0;
            bResp_q  <= 2'b00;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= (!wrMapped || wrReject) ? 2'b10 : 2'b00;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    // Configuration registers with reset values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_q[i] <= 32'h0000_0000;
            end
            cfg_q[IDX_PDLY] <= RST_PDLY;
            cfg_q[IDX_CDLY] <= RST_CDLY;
            cfg_q[IDX_VDLY] <= RST_VDLY;
        end else if (doWrite && wrMapped && !wrReject) begin
            cfg_q[awIdx_q] <= wMerged;
        end
    end

    // Read channel
    assign arIdx    = s_axi_araddr[6:2];
    assign rdMapped = arIdx <= IDX_INSTAT;
    assign rdMux    = (arIdx == IDX_STATUS) ? statusWord :
                      (arIdx == IDX_INSTAT) ? inStatWord :
                      (arIdx < IDX_STATUS)  ? cfg_q[arIdx] : 32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdState_q <= RD_IDLE;
            rData_q   <= 32'h0000_0000;
            rResp_q   <= 2'b00;
        end else begin
            case (rdState_q)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState_q <= RD_RESP;
                        rData_q   <= rdMux;
                        rResp_q   <= rdMapped ? 2'b00 : 2'b10;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        rdState_q <= RD_IDLE;
                    end
                end
                default: rdState_q <= RD_IDLE;
            endcase
        end
    end

    // --------
    // Field pin synchronisers and half-second tick
    // --------
    logic [NP-1:0]   pinS1_q;
    logic [NP-1:0]   pinS2_q;
    logic [NP-1:0]   pinS3_q;
    logic [NP-1:0]   pin_q;
    logic            keyPrev_q;
    logic            keyPress;
    logic [31:0]     tickCnt_q;
    logic            tick;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinS1_q <= '0;
            pinS2_q <= '0;
            pinS3_q <= '0;
            pin_q   <= '0;
        end else begin
            pinS1_q <= {resetKey, isolatorClosed, switchClosed};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            pin_q   <= (pinS2_q & pinS3_q) | (pin_q & (pinS2_q | pinS3_q));
        end
    end

    assign keyPress = pin_q[NP-1] && !keyPrev_q;
    assign tick     = (tickCnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keyPrev_q <= 1'b0;
            tickCnt_q <= 32'h0000_0000;
        end else begin
            keyPrev_q <= pin_q[NP-1];
            tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
        end
    end

    // --------
    // Settings decode and pickup conditions
    // --------
    logic            ptOn;
    logic            accelActive_q;
    logic [NT-1:0]   cond;
    logic [12:0]     lim [NT];
    logic [NT-1:0]   fire;
    logic [15:0]     lpAlm;
    logic [15:0]     lpTrp;
    logic [7:0]      ucAlm;
    logic [7:0]      ucTrp;
    logic [7:0]      stallLv;
    logic [9:0]      stallPct;
    logic            curHigh;

    assign ptOn     = cfg_q[IDX_CTRL][CTRL_PT_EN];
    assign lpAlm    = cfg_q[IDX_PWR][15:0];
    assign lpTrp    = cfg_q[IDX_PWR][31:16];
    assign ucAlm    = cfg_q[IDX_CURR][15:8];
    assign ucTrp    = cfg_q[IDX_CURR][23:16];
    assign stallLv  = cfg_q[IDX_CURR][31:24];
    assign stallPct = 10'(stallLv * STALL_STEP_PCT);
    assign curHigh  = currentPct >= FULL_LOAD_PCT;

    // Start supervision: inrush lasts until current falls below full load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accelActive_q <= 1'b0;
        end else if (startCmd) begin
            accelActive_q <= 1'b1;
        end else if (!curHigh) begin
            accelActive_q <= 1'b0;
        end
    end

    // Element pickups; a zero or cleared level means OFF
    assign cond[0]  = ptOn && lpAlm != 0 && {2'b00, powerKw} < lpAlm;
    assign cond[1]  = ptOn && lpTrp != 0 && {2'b00, powerKw} < lpTrp && motorRunning;
    assign cond[2]  = accelActive_q && cfg_q[IDX_ACCEL][7:0] != 0;
    assign cond[3]  = accelActive_q && cfg_q[IDX_ACCEL][15:8] != 0;
    assign cond[4]  = ucAlm != 0 && currentPct < {2'b00, ucAlm} && motorRunning;
    assign cond[5]  = ucTrp != 0 && currentPct < {2'b00, ucTrp} && motorRunning;
    assign cond[6]  = stallLv != 0 && motorRunning && !accelActive_q
                      && currentPct > stallPct;
    assign cond[7]  = ptOn && cfg_q[IDX_VLOW][VLEV_EN_LO]
                      && lineVolts < cfg_q[IDX_VLOW][9:0];
    assign cond[8]  = ptOn && cfg_q[IDX_VLOW][VLEV_EN_HI] && motorRunning
                      && lineVolts < cfg_q[IDX_VLOW][25:16];
    assign cond[9]  = ptOn && cfg_q[IDX_VHIGH][VLEV_EN_LO]
                      && lineVolts > cfg_q[IDX_VHIGH][9:0];
    assign cond[10] = ptOn && cfg_q[IDX_VHIGH][VLEV_EN_HI] && motorRunning
                      && lineVolts > cfg_q[IDX_VHIGH][25:16];

    // Limits in half-second ticks
    assign lim[0]  = {6'h00, cfg_q[IDX_PDLY][5:0], 1'b0};
    assign lim[1]  = {6'h00, cfg_q[IDX_PDLY][13:8], 1'b0};
    assign lim[2]  = {5'h00, cfg_q[IDX_ACCEL][7:0]};
    assign lim[3]  = {5'h00, cfg_q[IDX_ACCEL][15:8]};
    assign lim[4]  = {6'h00, cfg_q[IDX_CDLY][5:0], 1'b0};
    assign lim[5]  = {6'h00, cfg_q[IDX_CDLY][13:8], 1'b0};
    assign lim[6]  = {9'h000, cfg_q[IDX_CDLY][19:16]};
    assign lim[7]  = {6'h00, cfg_q[IDX_VDLY][5:0], 1'b0};
    assign lim[8]  = {6'h00, cfg_q[IDX_VDLY][13:8], 1'b0};
    assign lim[9]  = {6'h00, cfg_q[IDX_VDLY][21:16], 1'b0};
    assign lim[10] = {6'h00, cfg_q[IDX_VDLY][29:24], 1'b0};

    // --------
    // Programmable inputs
    // --------
    logic [NUM_INPUTS-1:0] unhealthy;
    logic [NUM_INPUTS-1:0] isProc;
    logic [NUM_INPUTS-1:0] isPlant;
    logic [NUM_INPUTS-1:0] latchedOp;

    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_in
        logic [31:0] c;
        logic [11:0] ovr;
        assign c = cfg_q[IDX_INCFG + g];
        // Closed contact is healthy unless polarity is normally closed
        assign unhealthy[g] = !(pin_q[g] ^ c[IN_POL_NC]);
        assign isProc[g]    = c[4:0] >= FN_PROC_A && c[4:0] <= FN_PROC_J;
        assign isPlant[g]   = c[4:0] == FN_PLANT;
        assign latchedOp[g] = c[IN_LATCHED];
        assign ovr          = accelActive_q ? c[19:8] : c[31:20];
        assign cond[11 + g] = isProc[g] && unhealthy[g] && ovr != OVR_OFF
                              && (motorRunning || accelActive_q);
        assign lim[11 + g]  = {ovr, 1'b0};
        assign interlockAlarm[g] = isProc[g] && c[IN_INST_ALM]
                                   && unhealthy[g];
        assign dupHit[g] = (wrIn != 5'(g)) && wData_q[4:0] != FN_NOT_USED
                           && c[4:0] == wData_q[4:0] && wStrb_q[0];
    end

    // --------
    // Qualifying delay timers
    // --------
    for (genvar t = 0; t < NT; t++) begin : g_tmr
        logic [12:0] cnt_q;
        // Clears on dropout so only a continuous pickup times out
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cnt_q <= 13'h0000;
            end else if (!cond[t]) begin
                cnt_q <= 13'h0000;
            end else if (tick && cnt_q != 13'h1FFF) begin
                cnt_q <= cnt_q + 13'h0001;
            end
        end
        assign fire[t] = cond[t] && cnt_q >= lim[t];
    end

    // --------
    // Alarm and trip outputs
    // --------
    logic            keyAlarms;
    logic            accAlm_q;
    trips_t          tripLatch_q;
    logic            isoTrip;
    logic            plantTrip;
    logic            ilkFire;
    logic            ilkStopNow;
    trips_t          tripSet;

    assign keyAlarms  = cfg_q[IDX_CTRL][CTRL_KEY_ALM];
    assign isoTrip    = cfg_q[IDX_CTRL][CTRL_ISO_EN] && !pin_q[NP-2];
    assign plantTrip  = |(isPlant & unhealthy);
    assign ilkFire    = |(fire[NT-1:11] & latchedOp);
    assign ilkStopNow = |(fire[NT-1:11] & ~latchedOp);

    assign tripSet = {ilkFire, 2'b00, fire[10], fire[8], fire[6], fire[5], fire[3], fire[1]};

    // Latched trips clear on a key press once their cause is gone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tripLatch_q <= '0;
            accAlm_q    <= 1'b0;
        end else begin
            tripLatch_q <= tripSet | (tripLatch_q & ~(keyPress ? ~tripSet : '0));
            accAlm_q    <= fire[2] || (accAlm_q && keyAlarms && !keyPress);
        end
    end

    // Registered protection outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarms        <= '0;
            trips         <= '0;
            interlockStop <= 1'b0;
        end else begin
            alarms.lowPower     <= fire[0];
            alarms.accel        <= accAlm_q || fire[2];
            alarms.loadIncrease <= cfg_q[IDX_CURR][7:0] != 0
                                   && currentPct > {2'b00, cfg_q[IDX_CURR][7:0]};
            alarms.underCurrent <= fire[4];
            alarms.underVolt    <= fire[7];
            alarms.overVolt     <= fire[9];
            trips               <= tripLatch_q | tripSet;
            trips.isolator      <= isoTrip;
            trips.plant         <= plantTrip;
            interlockStop       <= ilkStopNow;
        end
    end

    assign statusWord = {16'h0000, interlockStop, trips, alarms};
    assign inStatWord = {12'h000, fire[NT-1:11], unhealthy};

endmodule

// ==== motor_prot_asserts.sv ====
`timescale 1ns/1ps
module motor_prot_asserts
    import motor_prot_pkg::*;
(
    // Clock, reset and bus handshakes
    input wire logic                    clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic                    s_axi_rvalid, s_axi_rready,
    input wire logic [31:0]             s_axi_rdata,
    // Motor state and protection outputs
    input wire logic                    motorRunning, isolatorClosed,
    input wire logic [9:0]              currentPct,
    input wire motor_prot_pkg::alarms_t alarms,
    input wire motor_prot_pkg::trips_t  trips
);
    // --------
    // Bus and protection checks
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data missing");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
    iso_clear_a: assert property (isolatorClosed [*8] |-> !trips.isolator)
        else $error("isolator trip with input closed");
    lp_run_a: assert property ($rose(trips.lowPower) |-> $past(motorRunning, 2))
        else $error("low power trip while stopped");
    uv_run_a: assert property ($rose(trips.underVolt) |-> $past(motorRunning, 2))
        else $error("low voltage trip while stopped");
    accel_high_a: assert property ($rose(trips.accel) |-> $past(currentPct, 2) >= 10'h064)
        else $error("accel trip with current below full load");
    lp_trip_c: cover property ($rose(trips.lowPower));
    iso_trip_c: cover property ($rose(trips.isolator));
    ov_alarm_c: cover property ($rose(alarms.overVolt));
endmodule

bind motor_load_voltage_protection motor_prot_asserts chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .motorRunning, .isolatorClosed, .currentPct, .alarms, .trips);

// ==== starter_model.sv ====
`timescale 1ns/1ps
// Starter: runs from a start pulse, draws inrush, then the load current
module starter_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       startCmd,
    input  wire logic [9:0] loadPct,
    output logic            motorRunning,
    output logic [9:0]      currentPct
);
    logic [3:0] inrushCnt;
    // Inrush window restarts on every start pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motorRunning <= 1'b0;
            inrushCnt    <= 4'h0;
        end else if (startCmd) begin
            motorRunning <= 1'b1;
            inrushCnt    <= 4'h8;
        end else if (inrushCnt != 4'h0) begin
            inrushCnt <= inrushCnt - 4'h1;
        end
    end
    assign currentPct = !motorRunning ? 10'h000 : (inrushCnt != 4'h0 ? 10'h258 : loadPct);
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import motor_prot_pkg::*;
    logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [13:0] powerKw = 14'h01F4;
    logic [9:0] lineVolts = 10'h012C, loadPct = 10'h0050, currentPct;
    logic motorRunning, startCmd = 0, isolatorClosed = 1, resetKey = 0, interlockStop;
    logic [NUM_INPUTS-1:0] switchClosed = '1, interlockAlarm;
    alarms_t alarms;
    trips_t trips;
    int bad_count = 0, checks_done = 0, cycles = 0;
    logic [65:0] rq[$];
    logic [1:0] wq[$];
    motor_load_voltage_protection #(.TICK_CYC(4)) dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .powerKw, .currentPct, .lineVolts, .motorRunning, .startCmd, .switchClosed, .isolatorClosed, .resetKey,
        .alarms, .trips, .interlockAlarm, .interlockStop);
    starter_model starter (.clk, .rst, .startCmd, .loadPct, .motorRunning, .currentPct);
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %0t saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Bus tasks hold each channel until its own handshake edge
    task automatic wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge clk);
        wq.push_back(rsp);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] idx, input logic [31:0] m, input logic [31:0] e, input logic [1:0] rsp);
        @(posedge clk);
        rq.push_back({rsp, m, e});
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic st(input logic [14:0] m, input logic [14:0] e);
        rd(IDX_STATUS, 32'(m), 32'(e), 2'b00);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Result watcher pairs each answer with the oldest note
    always @(posedge clk) begin
        logic [65:0] e;
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            chk({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
        end
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(wq.pop_front()));
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(64536));
        switchClosed[9:1] <= 9'($urandom);
        pause(6);
        rst <= 1'b0;
        rd(IDX_PDLY, '1, RST_PDLY, 2'b00);
        rd(IDX_CDLY, '1, RST_CDLY, 2'b00);
        rd(IDX_VDLY, '1, RST_VDLY, 2'b00);
        rd(5'h1F, 32'h0000_0000, 32'h0000_0000, 2'b10);
        wr(IDX_STATUS, 32'h0000_0001, 2'b10);
        wr(IDX_INCFG, 32'h0000_0001, 2'b00);
        wr(IDX_INCFG + 5'h01, 32'h0000_0001, 2'b10);
        rd(IDX_INCFG + 5'h01, 32'h0000_001F, 32'h0000_0000, 2'b00);
        $display("registers done");
        wr(IDX_PWR, 32'h0064_0064, 2'b00);
        wr(IDX_PDLY, 32'h0000_0202, 2'b00);
        startCmd <= 1'b1;
        @(posedge clk) startCmd <= 1'b0;
        powerKw <= 14'($urandom_range(99, 1));
        pause(60);
        st(15'h0041, 15'h0000);
        powerKw <= 14'h01F4;
        wr(IDX_CTRL, 32'h0000_0001, 2'b00);
        repeat (3) begin
            powerKw <= 14'($urandom_range(99, 1));
            pause(10);
            powerKw <= 14'h01F4;
            pause(2);
        end
        st(15'h0041, 15'h0000);
        powerKw <= 14'($urandom_range(99, 1));
        pause(40);
        st(15'h0041, 15'h0041);
        powerKw <= 14'h01F4;
        pause(8);
        st(15'h0041, 15'h0040);
        resetKey <= 1'b1;
        pause(8);
        resetKey <= 1'b0;
        pause(8);
        st(15'h0040, 15'h0000);
        $display("power done");
        wr(IDX_VDLY, 32'h0202_0202, 2'b00);
        wr(IDX_VLOW, 32'h80C8_80C8, 2'b00);
        wr(IDX_VHIGH, 32'h8190_8190, 2'b00);
        for (int i = 0; i < 2; i++) begin
            lineVolts <= i ? 10'h1F4 : 10'h064;
            pause(40);
            st(i ? 15'h0820 : 15'h0410, i ? 15'h0820 : 15'h0410);
        end
        lineVolts <= 10'h012C;
        $display("voltage done");
        wr(IDX_ACCEL, 32'h0000_0404, 2'b00);
        loadPct <= 10'h12C;
        startCmd <= 1'b1;
        @(posedge clk) startCmd <= 1'b0;
        pause(40);
        st(15'h0082, 15'h0082);
        loadPct <= 10'h050;
        wr(IDX_CTRL, 32'h0000_0005, 2'b00);
        isolatorClosed <= 1'b0;
        pause(10);
        st(15'h1000, 15'h1000);
        isolatorClosed <= 1'b1;
        pause(10);
        st(15'h1000, 15'h0000);
        for (int p = 0; p < 2; p++) begin
            wr(IDX_INCFG, {24'h00_0000, p[0], 2'b10, FN_PROC_A}, 2'b00);
            for (int c = 0; c < 2; c++) begin
                switchClosed[0] <= c[0];
                pause(6);
                rd(IDX_INSTAT, 32'h0000_0401, 32'({c == p, 9'h000, c == p}), 2'b00);
                chk(34'({interlockStop, interlockAlarm[0]}), 34'({2{c == p}}));
            end
        end
        $display("inputs done");
        tally_and_finish();
    end
endmodule
